/* File: src/dtx_consts.svh */
// Constants for the device transmit frame sequencer.
`ifndef DTX_CONSTS_SVH
`define DTX_CONSTS_SVH
`define DTX_TYPE_DMA_ACT 8'h01
`define DTX_TYPE_FP_SETUP 8'h02
`define DTX_TYPE_DATA 8'h03
`define DTX_TYPE_SELFTEST 8'h04
`define DTX_LEN_DMA_ACT 3'h1
`define DTX_LEN_FP_SETUP 3'h7
`define DTX_LEN_SELFTEST 3'h3
`define DTX_FP_DIR_BIT 13
`define DTX_FP_INT_BIT 14
`endif

/* File: src/dtx_pkg.sv */
// Types for the device transmit frame sequencer.
package dtx_pkg;
  typedef enum logic [3:0] {
    transport_idle_state = 4'h0,
    dma_activate_build_state = 4'h1,
    dma_activate_status_state = 4'h2,
    fp_dma_setup_build_state = 4'h3,
    fp_dma_setup_status_state = 4'h4,
    data_in_prepare_state = 4'h5,
    data_in_word_state = 4'h6,
    data_in_end_state = 4'h7,
    selftest_frame_build_state = 4'h8,
    selftest_status_state = 4'h9
  } dtx_state_t;
endpackage

/* File: src/dtx_tx_sequencer.sv */
// Device transport transmit sequencer for four frame types.
//
// Functional notes
// - Idle enters build state matching app request.
// - DMA activate: build, flag pending, hand over.
// - Last word taken: complete, then await status.
// - Link illegal-transition notice returns to idle.
// - DMA activate status: idle, or report, resend.
// - Setup frame carries direction, buffer, offset, count, flag.
// - Setup frame followed by data in that direction; setup ends in idle, data needs its own request.
// - Setup request: build, flag pending, hand over.
// - Setup status: idle, or report and resend.
// - Data frame waits ready and data available.
// - One word per step until last, then end.
// - Application abort during words goes to end.
// - Data end: await status, report error, idle.
// - Abort reported to link, frame closed normally.
// - Early end on received DMAT is not done.
// - Self-test frame sent: complete, await status.
// - Self-test status: idle, or resend on error.
// - Successful self-test send tells application.
`timescale 1ns/1ps
`include "dtx_consts.svh"

module dtx_tx_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Application requests, taken only while idle
  input wire logic app_req_dma_act,
  input wire logic app_req_fp_setup,
  input wire logic app_req_data,
  input wire logic app_req_selftest,
  output logic app_req_ack,
  output logic app_busy,
  // Setup frame contents
  input wire logic fp_dir,
  input wire logic [63:0] fp_buf_id,
  input wire logic [31:0] fp_buf_off,
  input wire logic [31:0] fp_count,
  input wire logic fp_int,
  // Self-test frame contents
  input wire logic [23:0] st_pattern,
  input wire logic [31:0] st_data1,
  input wire logic [31:0] st_data2,
  // Application data stream
  input wire logic [31:0] app_data,
  input wire logic app_data_valid,
  input wire logic app_data_last,
  input wire logic app_abort,
  output logic app_data_take,
  // Application completion
  output logic app_frame_done,
  output logic app_frame_err,
  output logic app_selftest_ok,
  // Link layer
  output logic lnk_frame_pending,
  output logic [31:0] lnk_word,
  output logic lnk_word_valid,
  input wire logic lnk_word_ready,
  output logic lnk_tx_done,
  output logic lnk_abort_note,
  output logic lnk_status_report,
  input wire logic lnk_status_valid,
  input wire logic lnk_status_err,
  input wire logic lnk_illegal
);

  ////////////////////////////////////////////////////////////////////////
  // Frame layout helpers

  function automatic logic [2:0] frame_len(input dtx_pkg::dtx_state_t s);
    case (s)
      dtx_pkg::dma_activate_build_state: frame_len = `DTX_LEN_DMA_ACT;
      dtx_pkg::fp_dma_setup_build_state: frame_len = `DTX_LEN_FP_SETUP;
      dtx_pkg::selftest_frame_build_state: frame_len = `DTX_LEN_SELFTEST;
      default: frame_len = 3'h1;
    endcase
  endfunction

  function automatic logic [31:0] frame_word(
    input dtx_pkg::dtx_state_t s,
    input logic [2:0] i,
    input logic dir,
    input logic intr,
    input logic [63:0] bid,
    input logic [31:0] off,
    input logic [31:0] cnt,
    input logic [23:0] pat,
    input logic [31:0] d1,
    input logic [31:0] d2
  );
    logic [31:0] w0;
    w0 = 32'h0000_0000;
    case (s)
      dtx_pkg::dma_activate_build_state: frame_word = {24'h00_0000, `DTX_TYPE_DMA_ACT};
      dtx_pkg::fp_dma_setup_build_state:
      begin
        w0[7:0] = `DTX_TYPE_FP_SETUP;
        w0[`DTX_FP_DIR_BIT] = dir;
        w0[`DTX_FP_INT_BIT] = intr;
        case (i)
          3'h0: frame_word = w0;
          3'h1: frame_word = bid[31:0];
          3'h2: frame_word = bid[63:32];
          3'h4: frame_word = off;
          3'h5: frame_word = cnt;
          default: frame_word = 32'h0000_0000;
        endcase
      end
      dtx_pkg::selftest_frame_build_state:
      begin
        case (i)
          3'h0: frame_word = {pat, `DTX_TYPE_SELFTEST};
          3'h1: frame_word = d1;
          default: frame_word = d2;
        endcase
      end
      default: frame_word = {24'h00_0000, `DTX_TYPE_DATA};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State and held request fields

  dtx_pkg::dtx_state_t st_r;
  logic [2:0] idx_r;
  logic dir_r;
  logic int_r;
  logic [63:0] bid_r;
  logic [31:0] off_r;
  logic [31:0] cnt_r;
  logic [23:0] pat_r;
  logic [31:0] d1_r;
  logic [31:0] d2_r;
  logic last_r;
  logic any_req;
  logic is_build;
  logic is_status;
  logic word_take;
  logic last_take;
  logic slot_free;
  logic data_load;
  dtx_pkg::dtx_state_t req_st;

  assign any_req = app_req_dma_act | app_req_fp_setup | app_req_data | app_req_selftest;
  assign is_build = (st_r == dtx_pkg::dma_activate_build_state) ||
                    (st_r == dtx_pkg::fp_dma_setup_build_state) ||
                    (st_r == dtx_pkg::selftest_frame_build_state);
  assign is_status = (st_r == dtx_pkg::dma_activate_status_state) ||
                     (st_r == dtx_pkg::fp_dma_setup_status_state) ||
                     (st_r == dtx_pkg::selftest_status_state);
  assign word_take = lnk_word_valid && lnk_word_ready;
  assign last_take = word_take && is_build && (idx_r == frame_len(st_r) - 3'h1);
  assign slot_free = !lnk_word_valid || lnk_word_ready;
  // The take pulse lags a load by one cycle, so a load is skipped while it
  // is high; otherwise the old word would be loaded twice.
  assign data_load = (st_r == dtx_pkg::data_in_word_state) && slot_free &&
                     app_data_valid && !app_data_take && !(lnk_word_valid && last_r);

  always_comb
  begin
    // Fixed priority when several requests arrive together.
    if (app_req_dma_act)
      req_st = dtx_pkg::dma_activate_build_state;
    else if (app_req_fp_setup)
      req_st = dtx_pkg::fp_dma_setup_build_state;
    else if (app_req_data)
      req_st = dtx_pkg::data_in_prepare_state;
    else
      req_st = dtx_pkg::selftest_frame_build_state;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dir_r <= 1'b0;
      int_r <= 1'b0;
      bid_r <= 64'h0000_0000_0000_0000;
      off_r <= 32'h0000_0000;
      cnt_r <= 32'h0000_0000;
      pat_r <= 24'h00_0000;
      d1_r <= 32'h0000_0000;
      d2_r <= 32'h0000_0000;
    end
    else if (st_r == dtx_pkg::transport_idle_state && any_req)
    begin
      // Fields are frozen so a retry resends exactly the same frame.
      dir_r <= fp_dir;
      int_r <= fp_int;
      bid_r <= fp_buf_id;
      off_r <= fp_buf_off;
      cnt_r <= fp_count;
      pat_r <= st_pattern;
      d1_r <= st_data1;
      d2_r <= st_data2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st_r <= dtx_pkg::transport_idle_state;
    else if (st_r != dtx_pkg::transport_idle_state && lnk_illegal)
      st_r <= dtx_pkg::transport_idle_state;
    else
    begin
      case (st_r)
        dtx_pkg::transport_idle_state:
          if (any_req)
            st_r <= req_st;
        dtx_pkg::dma_activate_build_state:
          if (last_take)
            st_r <= dtx_pkg::dma_activate_status_state;
        dtx_pkg::fp_dma_setup_build_state:
          if (last_take)
            st_r <= dtx_pkg::fp_dma_setup_status_state;
        dtx_pkg::selftest_frame_build_state:
          if (last_take)
            st_r <= dtx_pkg::selftest_status_state;
        dtx_pkg::dma_activate_status_state,
        dtx_pkg::fp_dma_setup_status_state,
        dtx_pkg::selftest_status_state:
          if (lnk_status_valid)
          begin
            if (!lnk_status_err)
              st_r <= dtx_pkg::transport_idle_state;
            else if (st_r == dtx_pkg::dma_activate_status_state)
              st_r <= dtx_pkg::dma_activate_build_state;
            else if (st_r == dtx_pkg::fp_dma_setup_status_state)
              st_r <= dtx_pkg::fp_dma_setup_build_state;
            else
              st_r <= dtx_pkg::selftest_frame_build_state;
          end
        // The header may go out before the first data word is ready, so the
        // move also happens later, once the header slot has emptied.
        dtx_pkg::data_in_prepare_state:
          if ((word_take || !lnk_word_valid) && app_data_valid)
            st_r <= dtx_pkg::data_in_word_state;
        dtx_pkg::data_in_word_state:
          if (app_abort || (word_take && last_r))
            st_r <= dtx_pkg::data_in_end_state;
        dtx_pkg::data_in_end_state:
          if (lnk_status_valid)
            st_r <= dtx_pkg::transport_idle_state;
        default: st_r <= dtx_pkg::transport_idle_state;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word hand-over to the link

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      idx_r <= 3'h0;
      lnk_word <= 32'h0000_0000;
      lnk_word_valid <= 1'b0;
      last_r <= 1'b0;
      app_data_take <= 1'b0;
    end
    else
    begin
      app_data_take <= 1'b0;
      if (st_r != dtx_pkg::transport_idle_state && lnk_illegal)
        lnk_word_valid <= 1'b0;
      else if (st_r == dtx_pkg::transport_idle_state && any_req)
      begin
        idx_r <= 3'h0;
        last_r <= 1'b0;
        lnk_word <= frame_word(req_st, 3'h0, fp_dir, fp_int, fp_buf_id, fp_buf_off,
                               fp_count, st_pattern, st_data1, st_data2);
        lnk_word_valid <= 1'b1;
      end
      else if (is_status && lnk_status_valid && lnk_status_err)
      begin
        idx_r <= 3'h0;
        lnk_word <= frame_word(st_r == dtx_pkg::selftest_status_state ?
                               dtx_pkg::selftest_frame_build_state :
                               dtx_pkg::fp_dma_setup_build_state,
                               3'h0, dir_r, int_r, bid_r, off_r, cnt_r, pat_r, d1_r, d2_r);
        if (st_r == dtx_pkg::dma_activate_status_state)
          lnk_word <= {24'h00_0000, `DTX_TYPE_DMA_ACT};
        lnk_word_valid <= 1'b1;
      end
      else if (is_build && word_take)
      begin
        if (last_take)
          lnk_word_valid <= 1'b0;
        else
        begin
          idx_r <= idx_r + 3'h1;
          lnk_word <= frame_word(st_r, idx_r + 3'h1, dir_r, int_r, bid_r, off_r, cnt_r,
                                 pat_r, d1_r, d2_r);
        end
      end
      else if (st_r == dtx_pkg::data_in_prepare_state && word_take)
        lnk_word_valid <= 1'b0;
      else if (st_r == dtx_pkg::data_in_word_state)
      begin
        if (app_abort)
          lnk_word_valid <= 1'b0;
        else if (data_load)
        begin
          lnk_word <= app_data;
          last_r <= app_data_last;
          lnk_word_valid <= 1'b1;
          app_data_take <= 1'b1;
        end
        else if (word_take)
          lnk_word_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link and application signalling

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lnk_frame_pending <= 1'b0;
      lnk_tx_done <= 1'b0;
      lnk_abort_note <= 1'b0;
      lnk_status_report <= 1'b0;
      app_req_ack <= 1'b0;
      app_busy <= 1'b0;
      app_frame_done <= 1'b0;
      app_frame_err <= 1'b0;
      app_selftest_ok <= 1'b0;
    end
    else
    begin
      app_req_ack <= (st_r == dtx_pkg::transport_idle_state) && any_req;
      lnk_tx_done <= 1'b0;
      lnk_abort_note <= 1'b0;
      lnk_status_report <= 1'b0;
      app_frame_done <= 1'b0;
      app_frame_err <= 1'b0;
      app_selftest_ok <= 1'b0;
      if (st_r != dtx_pkg::transport_idle_state && lnk_illegal)
      begin
        lnk_frame_pending <= 1'b0;
        app_busy <= 1'b0;
        app_frame_err <= 1'b1;
      end
      else
      begin
        if (st_r == dtx_pkg::transport_idle_state && any_req)
        begin
          lnk_frame_pending <= 1'b1;
          app_busy <= 1'b1;
        end
        if (last_take)
        begin
          lnk_tx_done <= 1'b1;
          lnk_frame_pending <= 1'b0;
        end
        if (st_r == dtx_pkg::data_in_word_state && (app_abort || (word_take && last_r)))
        begin
          // An abort still closes the frame normally so the link adds a good CRC.
          lnk_tx_done <= 1'b1;
          lnk_abort_note <= app_abort;
          lnk_frame_pending <= 1'b0;
        end
        if ((is_status || st_r == dtx_pkg::data_in_end_state) && lnk_status_valid)
        begin
          // Self-test retries silently; the other frames report the error.
          lnk_status_report <= lnk_status_err &&
                               (st_r != dtx_pkg::selftest_status_state);
          if (lnk_status_err && st_r != dtx_pkg::data_in_end_state)
            lnk_frame_pending <= 1'b1;
          else
          begin
            app_busy <= 1'b0;
            app_frame_done <= !lnk_status_err;
            app_frame_err <= lnk_status_err;
            app_selftest_ok <= !lnk_status_err &&
                               (st_r == dtx_pkg::selftest_status_state);
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_status_err;
    is_status && lnk_status_valid && lnk_status_err && !lnk_illegal;
  endsequence

  sequence s_abort_in_words;
    st_r == dtx_pkg::data_in_word_state && app_abort && !lnk_illegal;
  endsequence

  a_last_word_done: assert property (last_take && !lnk_illegal |=>
    lnk_tx_done && is_status && !lnk_frame_pending)
    else $error("last frame word did not end the build");
  a_illegal_to_idle: assert property (st_r != dtx_pkg::transport_idle_state && lnk_illegal |=>
    st_r == dtx_pkg::transport_idle_state && !lnk_word_valid)
    else $error("illegal transition did not return to idle");
  a_retry_report: assert property (s_status_err |=>
    is_build && lnk_word_valid && idx_r == 3'h0 &&
    lnk_status_report == (st_r != dtx_pkg::selftest_frame_build_state))
    else $error("error status did not restart the frame");
  a_abort_to_end: assert property (s_abort_in_words |=>
    st_r == dtx_pkg::data_in_end_state && lnk_abort_note && lnk_tx_done ##1 !lnk_abort_note)
    else $error("abort did not close the data frame");
  a_data_end_idle: assert property (st_r == dtx_pkg::data_in_end_state && lnk_status_valid &&
    !lnk_illegal |=> st_r == dtx_pkg::transport_idle_state && !app_busy &&
    lnk_status_report == $past(lnk_status_err))
    else $error("data end did not go idle");
  a_selftest_ok: assert property (st_r == dtx_pkg::selftest_status_state && lnk_status_valid &&
    !lnk_status_err && !lnk_illegal |=> app_selftest_ok ##1 !app_selftest_ok)
    else $error("self-test success not signalled");
  a_ack_only_idle: assert property (app_req_ack |->
    $past(st_r) == dtx_pkg::transport_idle_state && st_r != dtx_pkg::transport_idle_state)
    else $error("request taken while busy");
  a_word_held: assert property (lnk_word_valid && !lnk_word_ready && !lnk_illegal &&
    !app_abort |=> lnk_word_valid && $stable(lnk_word))
    else $error("link word changed before it was taken");
  a_setup_fields: assert property (st_r == dtx_pkg::transport_idle_state && app_req_fp_setup &&
    !app_req_dma_act |=> lnk_word[7:0] == `DTX_TYPE_FP_SETUP &&
    lnk_word[`DTX_FP_DIR_BIT] == $past(fp_dir))
    else $error("setup frame header wrong");

endmodule

/* File: verif/dtx_link_model.sv */
// Behavioural link layer that takes frame words and returns ending status.
`timescale 1ns/1ps

module dtx_link_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bench controls
  input wire logic slow,
  input wire logic err_mode,
  input wire logic illegal_req,
  // Sequencer side
  input wire logic lnk_tx_done,
  output logic lnk_word_ready,
  output logic lnk_status_valid,
  output logic lnk_status_err,
  output logic lnk_illegal
);
  logic [2:0] wait_r;

  ////////////////////////////////////////////////////////////////////////////////
  // A slow link drops ready every other cycle, so a word must stand until it is taken.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lnk_word_ready <= 1'b0;
    else
      lnk_word_ready <= slow ? ~lnk_word_ready : 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Ending status follows each completed frame; the error line churns between
  // reports so that a stale value is never mistaken for a real one.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wait_r <= 3'h0;
      lnk_status_valid <= 1'b0;
      lnk_status_err <= 1'b0;
      lnk_illegal <= 1'b0;
    end
    else
    begin
      lnk_status_valid <= (wait_r == 3'h1);
      lnk_status_err <= (wait_r == 3'h1) ? err_mode : ~lnk_status_err;
      lnk_illegal <= illegal_req;
      if (lnk_tx_done)
        wait_r <= slow ? 3'h5 : 3'h1;
      else if (wait_r != 3'h0)
        wait_r <= wait_r - 3'h1;
    end
  end
endmodule

/* File: verif/device_transport_tx_fis_sequencer_tb.sv */
// Self-checking testbench for the device transmit frame sequencer.
`timescale 1ns/1ps
`include "dtx_consts.svh"

module device_transport_tx_fis_sequencer_tb;
  localparam logic [63:0] BID = 64'h0123456789ABCDEF;
  localparam logic [31:0] DBASE = 32'hC0DE0000;
  // Row layout: kind, slow link, error status, frame length in words.
  localparam logic [6:0] ROWS [12] = '{7'h01, 7'h11, 7'h09, 7'h27, 7'h37, 7'h2F,
    7'h44, 7'h54, 7'h4C, 7'h63, 7'h73, 7'h6B};
  logic clk, sys_rst, slow, err_mode, illegal_req;
  logic app_req_dma_act, app_req_fp_setup, app_req_data, app_req_selftest;
  logic app_req_ack, app_busy, app_data_take, app_frame_done, app_frame_err;
  logic app_selftest_ok, lnk_frame_pending, lnk_word_valid, lnk_word_ready, lnk_tx_done;
  logic lnk_abort_note, lnk_status_report, lnk_status_valid, lnk_status_err, lnk_illegal;
  logic app_data_valid, app_data_last, app_abort;
  logic fp_dir, fp_int;
  logic [23:0] st_pattern;
  logic [31:0] app_data, lnk_word;
  logic [31:0] wq[$];
  logic [1:0] k;
  logic sl, er;
  logic [2:0] len;
  int c[8], e[8];
  int errors, comparisons, cyc, kk, ndata, abort_at, t;

  dtx_tx_sequencer dtx_tx_sequencer_inst (.clk(clk), .sys_rst(sys_rst),
    .app_req_dma_act(app_req_dma_act), .app_req_fp_setup(app_req_fp_setup),
    .app_req_data(app_req_data), .app_req_selftest(app_req_selftest),
    .app_req_ack(app_req_ack), .app_busy(app_busy), .fp_dir(fp_dir),
    .fp_buf_id(BID), .fp_buf_off(32'h00001000), .fp_count(32'h00000200),
    .fp_int(fp_int), .st_pattern(st_pattern), .st_data1(32'h11112222),
    .st_data2(32'h33334444), .app_data(app_data), .app_data_valid(app_data_valid),
    .app_data_last(app_data_last), .app_abort(app_abort), .app_data_take(app_data_take),
    .app_frame_done(app_frame_done), .app_frame_err(app_frame_err),
    .app_selftest_ok(app_selftest_ok), .lnk_frame_pending(lnk_frame_pending),
    .lnk_word(lnk_word), .lnk_word_valid(lnk_word_valid), .lnk_word_ready(lnk_word_ready),
    .lnk_tx_done(lnk_tx_done), .lnk_abort_note(lnk_abort_note),
    .lnk_status_report(lnk_status_report), .lnk_status_valid(lnk_status_valid),
    .lnk_status_err(lnk_status_err), .lnk_illegal(lnk_illegal));

  dtx_link_model dtx_link_model_inst (.clk(clk), .sys_rst(sys_rst), .slow(slow),
    .err_mode(err_mode), .illegal_req(illegal_req), .lnk_tx_done(lnk_tx_done),
    .lnk_word_ready(lnk_word_ready), .lnk_status_valid(lnk_status_valid),
    .lnk_status_err(lnk_status_err), .lnk_illegal(lnk_illegal));

  ////////////////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;

  function automatic logic [31:0] exp_word(input logic [1:0] kd, input int i);
    logic [31:0] w;
    begin
      w = {24'h0, `DTX_TYPE_FP_SETUP};
      w[`DTX_FP_DIR_BIT] = fp_dir;
      w[`DTX_FP_INT_BIT] = fp_int;
      case (kd)
        2'h0: exp_word = {24'h0, `DTX_TYPE_DMA_ACT};
        2'h1: exp_word = (i == 0) ? w : (i == 1) ? BID[31:0] : (i == 2) ? BID[63:32] :
          (i == 4) ? 32'h00001000 : (i == 5) ? 32'h00000200 : 32'h0;
        2'h2: exp_word = (i == 0) ? {24'h0, `DTX_TYPE_DATA} : DBASE + i - 1;
        default: exp_word = (i == 0) ? {st_pattern, `DTX_TYPE_SELFTEST} :
          (i == 1) ? 32'h11112222 : 32'h33334444;
      endcase
    end
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    chk_word(got, exp);
  endtask

  task automatic chk_pulses();
    for (int j = 0; j < 8; j++)
      chk_cnt(c[j], e[j]);
    chk_word({lnk_frame_pending, lnk_word_valid, app_busy}, 32'h0000_0000);
  endtask

  task automatic finish_test();
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Requests stay high for the whole frame, so a second acceptance would show.
  task automatic run(input logic [1:0] kd, input logic s, input logic r, input int nd,
    input int ab, input logic il);
    int n;
    begin
      wq.delete();
      c = '{default: 0};
      slow = s;
      err_mode = r;
      fp_dir = s;
      fp_int = !r;
      st_pattern = s ? 24'h5A5A5A : 24'hA5A5A5;
      ndata = nd;
      abort_at = ab;
      kk = 0;
      {app_req_selftest, app_req_data, app_req_fp_setup, app_req_dma_act} = 4'h1 << kd;
      n = 0;
      while (!(c[0] > 0 && app_busy === 1'b0) && n < 400)
      begin
        @(negedge clk);
        n++;
        illegal_req = il && (n == 4);
        if (c[7] > 0)
          err_mode = 1'b0;
      end
      {app_req_selftest, app_req_data, app_req_fp_setup, app_req_dma_act} = 4'h0;
      repeat (2) @(negedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Application data source; a word advances after each take pulse.
  always @(negedge clk)
  begin
    if (app_data_take === 1'b1)
      kk++;
    app_data_valid = (kk < ndata);
    app_data = DBASE + kk;
    app_data_last = (kk == ndata - 1);
    app_abort = (abort_at >= 0) && (kk >= abort_at);
  end

  always @(posedge clk)
  begin
    cyc++;
    if (lnk_word_valid === 1'b1 && lnk_word_ready === 1'b1)
      wq.push_back(lnk_word);
    c[0] += (app_req_ack === 1'b1);
    c[1] += (lnk_tx_done === 1'b1);
    c[2] += (lnk_abort_note === 1'b1);
    c[3] += (lnk_status_report === 1'b1);
    c[4] += (app_frame_done === 1'b1);
    c[5] += (app_frame_err === 1'b1);
    c[6] += (app_selftest_ok === 1'b1);
    c[7] += (lnk_status_valid === 1'b1);
    if (cyc == 6000)
    begin
      errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {app_req_selftest, app_req_data, app_req_fp_setup, app_req_dma_act} = 4'h0;
    {slow, err_mode, illegal_req, app_data_valid, app_data_last, app_abort} = 6'h0;
    app_data = 32'h0;
    {fp_dir, fp_int, st_pattern} = 26'h0;
    errors = 0;
    comparisons = 0;
    cyc = 0;
    kk = 0;
    ndata = 0;
    abort_at = -1;
    repeat (9) @(negedge clk);
    chk_word({app_busy, lnk_word_valid, lnk_frame_pending, app_req_ack, lnk_tx_done}, 0);
    @(negedge clk);
    sys_rst = 1'b0;
    for (int r = 0; r < 12; r++)
    begin
      {k, sl, er, len} = ROWS[r];
      run(k, sl, er, (k == 2'h2) ? 3 : 0, -1, 1'b0);
      t = (er && k != 2'h2) ? 2 : 1;
      e = '{1, t, 0, int'(er && k != 2'h3), int'(!(k == 2'h2 && er)),
        int'(k == 2'h2 && er), int'(k == 2'h3), t};
      chk_pulses();
      chk_cnt(wq.size(), int'(len) * t);
      for (int i = 0; i < wq.size(); i++)
        chk_word(wq[i], exp_word(k, i % int'(len)));
    end
    // Abort in mid-stream: the frame closes normally and the link is told.
    run(2'h2, 1'b0, 1'b0, 8, 2, 1'b0);
    e = '{1, 1, 1, 0, 1, 0, 0, 1};
    chk_pulses();
    chk_cnt(int'(wq.size() >= 3 && wq.size() <= 5), 1);
    for (int i = 0; i < wq.size(); i++)
      chk_word(wq[i], exp_word(2'h2, i));
    // Illegal transition while building a slow setup frame, then mid-data.
    for (int m = 0; m < 2; m++)
    begin
      run(m ? 2'h2 : 2'h1, ~m[0], 1'b0, m ? 8 : 0, -1, 1'b1);
      e = '{1, 0, 0, 0, 0, 1, 0, 0};
      chk_pulses();
    end
    finish_test();
  end
endmodule
